// ===== shared/rssi_peak_defines.svh
// Constants of the RSSI peak detector unit: register offsets, field positions,
// widths and reset values.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef RSSI_PEAK_DEFINES_SVH
`define RSSI_PEAK_DEFINES_SVH

// ---------------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------------
`define RSSI_W            8
`define AVG_DEPTH         4
`define AVG_SUM_W         10
`define AVG_SHIFT         2
`define DELAY_W           4
`define APB_ADDR_W        8

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define PAYLOAD_PEAK_OFS  8'h00
`define RX_PEAK_OFS       8'h04
`define WAKEUP_PEAK_OFS   8'h08
`define PEAK_CONFIG_OFS   8'h0C
`define PEAK_STATUS_OFS   8'h10

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CFG_DELAY_LSB     0
`define STS_DONE_BIT      0
`define STS_TRACK_BIT     1
`define STS_DELAY_BIT     2
`define STS_RXRUN_BIT     3
`define STS_WUSEARCH_BIT  4

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PEAK_RESET        8'h00
`define DELAY_RESET       4'h0

`endif

// ===== shared/rssi_peak_pkg.sv
// Types of the RSSI peak detector unit.
// Assumes rssi_peak_defines.svh is compiled with it.
`include "rssi_peak_defines.svh"

package rssi_peak_pkg;

	// -----------------------------------------------------------------------
	// Averager state
	// -----------------------------------------------------------------------
	typedef struct packed {
		logic [`AVG_DEPTH-2:0][`RSSI_W-1:0] hist;
		logic [`RSSI_W-1:0]                 avg;
		logic                               avg_valid;
	} avg_state_t;

	// -----------------------------------------------------------------------
	// Payload window sequencing and register selection
	// -----------------------------------------------------------------------
	typedef enum logic [2:0] {
		PAY_IDLE  = 3'b001,
		PAY_DELAY = 3'b010,
		PAY_TRACK = 3'b100
	} pay_state_t;

	typedef enum logic [5:0] {
		SEL_NONE    = 6'b000001,
		SEL_PAYLOAD = 6'b000010,
		SEL_RX      = 6'b000100,
		SEL_WAKEUP  = 6'b001000,
		SEL_CONFIG  = 6'b010000,
		SEL_STATUS  = 6'b100000
	} reg_sel_t;

	// -----------------------------------------------------------------------
	// Detector unit state
	// -----------------------------------------------------------------------
	typedef struct packed {
		pay_state_t          pay_state;
		logic [`RSSI_W-1:0]  pay_det;
		logic [`RSSI_W-1:0]  pay_level;
		logic [`DELAY_W-1:0] delay_cnt;
		logic [`DELAY_W-1:0] cfg_delay;
		logic                pay_done;
		logic [`RSSI_W-1:0]  rx_det;
		logic [`RSSI_W-1:0]  rx_level;
		logic [`RSSI_W-1:0]  wu_det;
		logic [`RSSI_W-1:0]  wu_level;
		logic [31:0]         prdata;
		logic                pslverr;
	} unit_state_t;

endpackage

// ===== core/rssi_avg4.sv
// Four-sample moving average of the RSSI level.
// Assumes one raw sample per RSSI_VALID strobe, synchronous to the clock.
`timescale 1ns/100ps
`include "rssi_peak_defines.svh"

module rssi_avg4 (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Raw samples
	input  wire logic [`RSSI_W-1:0]  sample_i,
	input  wire logic                sample_valid_i,
	// Averaged samples
	output logic      [`RSSI_W-1:0]  avg_o,
	output logic                     avg_valid_o
);
	import rssi_peak_pkg::*;

	avg_state_t          state_r;
	avg_state_t          state_nxt;
	logic [`AVG_SUM_W-1:0] sum;

	// -----------------------------------------------------------------------
	// Window update
	// -----------------------------------------------------------------------
	// Window starts filled with zeros, so the first three averages read low;
	// that only delays a peak, it never fakes one.
	always_comb begin
		state_nxt = state_r;
		sum = `AVG_SUM_W'(sample_i);
		for (int i = 0; i < `AVG_DEPTH-1; i++) begin
			sum = sum + `AVG_SUM_W'(state_r.hist[i]);
		end
		state_nxt.avg_valid = sample_valid_i;
		if (sample_valid_i) begin
			state_nxt.avg = sum[`AVG_SUM_W-1:`AVG_SHIFT];
			for (int i = `AVG_DEPTH-2; i > 0; i--) begin
				state_nxt.hist[i] = state_r.hist[i-1];
			end
			state_nxt.hist[0] = sample_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign avg_o       = state_r.avg;
	assign avg_valid_o = state_r.avg_valid;

endmodule

// ===== core/rssi_peak_detector_unit.sv
// RSSI peak detector unit: payload, free-running receive and wake-up peak
// detectors fed from one four-sample average, with an APB register slave.
// Assumes framing and wake-up events are one-cycle pulses synchronous to
// CLOCK_I, and that RST_I is the power-up reset.
`timescale 1ns/100ps
`include "rssi_peak_defines.svh"

module rssi_peak_detector_unit (
	// Clock and reset
	input  wire logic                        CLOCK_I,
	input  wire logic                        RST_I,
	// APB slave
	input  wire logic                        PSEL_I,
	input  wire logic                        PENABLE_I,
	input  wire logic                        PWRITE_I,
	input  wire logic [`APB_ADDR_W-1:0]      PADDR_I,
	input  wire logic [31:0]                 PWDATA_I,
	output logic      [31:0]                 PRDATA_O,
	output logic                             PREADY_O,
	output logic                             PSLVERR_O,
	// RSSI samples
	input  wire logic [`RSSI_W-1:0]          RSSI_SAMPLE_I,
	input  wire logic                        RSSI_VALID_I,
	// Framer events
	input  wire logic                        FRAME_SYNC_DETECTED_I,
	input  wire logic                        END_OF_MESSAGE_I,
	input  wire logic                        DATA_BIT_I,
	// Receiver and wake-up generator
	input  wire logic                        RX_RUN_I,
	input  wire logic                        WAKEUP_SEARCH_I,
	input  wire logic                        CHANNEL_START_I,
	input  wire logic                        CHANNEL_END_I,
	input  wire logic                        WAKEUP_I,
	// Observation status
	output logic                             PAYLOAD_TRACKING_O,
	output rssi_peak_pkg::pay_state_t        PAYLOAD_STATE_O
);
	import rssi_peak_pkg::*;

	// -----------------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------------
	// Shared max-hold step of every detector.
	function automatic logic [`RSSI_W-1:0] peak_update(
		input logic [`RSSI_W-1:0] stored,
		input logic [`RSSI_W-1:0] smp,
		input logic               take
	);
		logic [`RSSI_W-1:0] res;
		res = stored;
		if (take && (smp > stored)) begin
			res = smp;
		end
		return res;
	endfunction

	// Address decode, used for both the setup and the access phase.
	function automatic reg_sel_t addr_decode(input logic [`APB_ADDR_W-1:0] addr);
		reg_sel_t sel;
		case (addr)
			`PAYLOAD_PEAK_OFS: begin
				sel = SEL_PAYLOAD;
			end
			`RX_PEAK_OFS: begin
				sel = SEL_RX;
			end
			`WAKEUP_PEAK_OFS: begin
				sel = SEL_WAKEUP;
			end
			`PEAK_CONFIG_OFS: begin
				sel = SEL_CONFIG;
			end
			`PEAK_STATUS_OFS: begin
				sel = SEL_STATUS;
			end
			default: begin
				sel = SEL_NONE;
			end
		endcase
		return sel;
	endfunction

	// -----------------------------------------------------------------------
	// Averaged RSSI
	// -----------------------------------------------------------------------
	logic [`RSSI_W-1:0] avg_level;
	logic               avg_valid;

	rssi_avg4 u_avg (
		.clk_i          (CLOCK_I),
		.rst_i          (RST_I),
		.sample_i       (RSSI_SAMPLE_I),
		.sample_valid_i (RSSI_VALID_I),
		.avg_o          (avg_level),
		.avg_valid_o    (avg_valid)
	);

	// -----------------------------------------------------------------------
	// State
	// -----------------------------------------------------------------------
	unit_state_t state_r;
	unit_state_t state_nxt;

	logic     setup_phase;
	logic     access_phase;
	reg_sel_t setup_sel;
	reg_sel_t access_sel;
	logic     rx_read;
	logic     status_clear;
	logic     tracking;

	assign setup_phase  = PSEL_I && !PENABLE_I;
	assign access_phase = PSEL_I && PENABLE_I;
	assign setup_sel    = addr_decode(PADDR_I);
	assign access_sel   = addr_decode(PADDR_I);
	// The side effect of a read happens once, at the completing edge.
	assign rx_read      = access_phase && !PWRITE_I && (access_sel == SEL_RX);
	assign status_clear = access_phase && PWRITE_I && (access_sel == SEL_STATUS)
		&& PWDATA_I[`STS_DONE_BIT];
	assign tracking     = (state_r.pay_state == PAY_TRACK);

	always_comb begin
		state_nxt = state_r;

		// -------------------------------------------------------------------
		// Payload detector
		// -------------------------------------------------------------------
		case (state_r.pay_state)
			PAY_IDLE: begin
			end
			PAY_DELAY: begin
				if (END_OF_MESSAGE_I) begin
					state_nxt.pay_level = state_r.pay_det;
					state_nxt.pay_state = PAY_IDLE;
				end else if (DATA_BIT_I) begin
					if (state_r.delay_cnt <= `DELAY_W'(1)) begin
						state_nxt.delay_cnt = `DELAY_RESET;
						state_nxt.pay_state = PAY_TRACK;
					end else begin
						state_nxt.delay_cnt = state_r.delay_cnt - `DELAY_W'(1);
					end
				end
			end
			PAY_TRACK: begin
				if (END_OF_MESSAGE_I) begin
					state_nxt.pay_level = peak_update(state_r.pay_det, avg_level,
						avg_valid);
					state_nxt.pay_state = PAY_IDLE;
				end else begin
					state_nxt.pay_det = peak_update(state_r.pay_det, avg_level,
						avg_valid);
				end
			end
			default: begin
				state_nxt.pay_state = PAY_IDLE;
			end
		endcase

		// A new sync restarts the window, even in the middle of a telegram.
		if (FRAME_SYNC_DETECTED_I) begin
			state_nxt.pay_det   = `PEAK_RESET;
			state_nxt.delay_cnt = state_r.cfg_delay;
			if (state_r.cfg_delay == `DELAY_RESET) begin
				state_nxt.pay_state = PAY_TRACK;
			end else begin
				state_nxt.pay_state = PAY_DELAY;
			end
		end

		// Done flag: a telegram ending in the clearing cycle keeps it set.
		if (status_clear) begin
			state_nxt.pay_done = 1'b0;
		end
		if (END_OF_MESSAGE_I && (state_r.pay_state != PAY_IDLE)
			&& !FRAME_SYNC_DETECTED_I) begin
			state_nxt.pay_done = 1'b1;
		end

		// -------------------------------------------------------------------
		// Receive detector
		// -------------------------------------------------------------------
		if (RX_RUN_I) begin
			if (rx_read) begin
				// Register takes the value returned on the bus.
				state_nxt.rx_level = state_r.prdata[`RSSI_W-1:0];
				state_nxt.rx_det   = avg_level;
			end else begin
				state_nxt.rx_det = peak_update(state_r.rx_det, avg_level,
					avg_valid);
			end
		end

		// -------------------------------------------------------------------
		// Wake-up detector
		// -------------------------------------------------------------------
		if (CHANNEL_START_I) begin
			state_nxt.wu_det = `PEAK_RESET;
		end else if (WAKEUP_SEARCH_I) begin
			state_nxt.wu_det = peak_update(state_r.wu_det, avg_level,
				avg_valid);
		end
		if (WAKEUP_I) begin
			state_nxt.wu_level = state_r.wu_det;
		end else if (CHANNEL_END_I) begin
			state_nxt.wu_level = state_r.wu_det;
		end

		// -------------------------------------------------------------------
		// APB setup: latch the answer for the access phase
		// -------------------------------------------------------------------
		if (setup_phase) begin
			state_nxt.prdata  = 32'h0000_0000;
			state_nxt.pslverr = 1'b0;
			case (setup_sel)
				SEL_PAYLOAD: begin
					state_nxt.prdata[`RSSI_W-1:0] = state_r.pay_level;
				end
				SEL_RX: begin
					// While running, a read returns the live detector value.
					if (RX_RUN_I) begin
						state_nxt.prdata[`RSSI_W-1:0] = state_r.rx_det;
					end else begin
						state_nxt.prdata[`RSSI_W-1:0] = state_r.rx_level;
					end
				end
				SEL_WAKEUP: begin
					state_nxt.prdata[`RSSI_W-1:0] = state_r.wu_level;
				end
				SEL_CONFIG: begin
					state_nxt.prdata[`CFG_DELAY_LSB +: `DELAY_W] = state_r.cfg_delay;
				end
				SEL_STATUS: begin
					state_nxt.prdata[`STS_DONE_BIT]     = state_r.pay_done;
					state_nxt.prdata[`STS_TRACK_BIT]    = tracking;
					state_nxt.prdata[`STS_DELAY_BIT]    = (state_r.pay_state == PAY_DELAY);
					state_nxt.prdata[`STS_RXRUN_BIT]    = RX_RUN_I;
					state_nxt.prdata[`STS_WUSEARCH_BIT] = WAKEUP_SEARCH_I;
				end
				SEL_NONE: begin
					state_nxt.pslverr = 1'b1;
				end
				default: begin
					state_nxt.pslverr = 1'b1;
				end
			endcase
		end

		// -------------------------------------------------------------------
		// APB access: writes take effect at the completing edge
		// -------------------------------------------------------------------
		if (access_phase && PWRITE_I && (access_sel == SEL_CONFIG)) begin
			state_nxt.cfg_delay = PWDATA_I[`CFG_DELAY_LSB +: `DELAY_W];
		end
	end

	// -----------------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------------
	// RST_I is the only source that clears the peak registers; the unit has
	// no soft reset on purpose.
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			state_r           <= '0;
			state_r.pay_state <= PAY_IDLE;
			state_r.pay_level <= `PEAK_RESET;
			state_r.rx_level  <= `PEAK_RESET;
			state_r.cfg_delay <= `DELAY_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// -----------------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------------
	// One wait-free access phase; the answer was latched during setup.
	assign PREADY_O           = 1'b1;
	assign PRDATA_O           = state_r.prdata;
	assign PSLVERR_O          = state_r.pslverr && access_phase;
	assign PAYLOAD_TRACKING_O = tracking;
	assign PAYLOAD_STATE_O    = state_r.pay_state;

endmodule

// ===== tb/rssi_peak_detector_unit_properties.sv
// Port-level checks of the RSSI peak detector unit, bound into the design.
// Assumes one clock domain and the synchronous power-up reset.
`timescale 1ns/100ps

module rssi_peak_checker (
	// Clock and reset
	input wire logic                      CLOCK_I,
	input wire logic                      RST_I,
	// APB
	input wire logic                      PSEL_I,
	input wire logic                      PENABLE_I,
	input wire logic                      PWRITE_I,
	input wire logic [31:0]               PRDATA_O,
	input wire logic                      PREADY_O,
	input wire logic                      PSLVERR_O,
	// Framing and status
	input wire logic                      FRAME_SYNC_DETECTED_I,
	input wire logic                      END_OF_MESSAGE_I,
	input wire logic                      DATA_BIT_I,
	input wire logic                      PAYLOAD_TRACKING_O,
	input wire rssi_peak_pkg::pay_state_t PAYLOAD_STATE_O
);
	import rssi_peak_pkg::*;

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	// ------------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------------
	AST_RESET_CLEAN: assert property (
		$fell(RST_I) |-> PRDATA_O == 32'h0 && !PSLVERR_O && PAYLOAD_STATE_O == PAY_IDLE)
		else $error("Outputs not cleared by reset");
	AST_READY_CONST: assert property (PREADY_O == 1'b1)
		else $error("Ready dropped");
	AST_ERR_IN_ACCESS: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
		else $error("Error outside access phase");
	AST_UPPER_ZERO: assert property (
		PSEL_I && PENABLE_I && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
		else $error("Read data upper bits set");
	AST_READ_HELD: assert property (PSEL_I && PENABLE_I |=> $stable(PRDATA_O))
		else $error("Read data moved after access");

	// ------------------------------------------------------------------
	// Payload window
	// ------------------------------------------------------------------
	AST_TRACK_FLAG: assert property (
		PAYLOAD_TRACKING_O == (PAYLOAD_STATE_O == PAY_TRACK))
		else $error("Tracking flag disagrees with state");
	AST_SYNC_OPENS: assert property (
		FRAME_SYNC_DETECTED_I |=> PAYLOAD_STATE_O != PAY_IDLE)
		else $error("Sync did not open window");
	AST_EOM_CLOSES: assert property (
		END_OF_MESSAGE_I && !FRAME_SYNC_DETECTED_I |=> PAYLOAD_STATE_O == PAY_IDLE)
		else $error("End of message did not close window");
	AST_IDLE_WAITS: assert property (
		PAYLOAD_STATE_O == PAY_IDLE && !FRAME_SYNC_DETECTED_I |=> PAYLOAD_STATE_O == PAY_IDLE)
		else $error("Window opened without sync");
	AST_DELAY_BITS: assert property (
		PAYLOAD_STATE_O == PAY_DELAY && !DATA_BIT_I && !END_OF_MESSAGE_I
		&& !FRAME_SYNC_DETECTED_I |=> PAYLOAD_STATE_O == PAY_DELAY)
		else $error("Delay left without a data bit");
	AST_TRACK_STAYS: assert property (
		PAYLOAD_STATE_O == PAY_TRACK && !END_OF_MESSAGE_I && !FRAME_SYNC_DETECTED_I
		|=> $stable(PAYLOAD_STATE_O))
		else $error("Tracking left without end of message");
endmodule

bind rssi_peak_detector_unit rssi_peak_checker u_props (
	.CLOCK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PRDATA_O, .PREADY_O, .PSLVERR_O,
	.FRAME_SYNC_DETECTED_I, .END_OF_MESSAGE_I, .DATA_BIT_I, .PAYLOAD_TRACKING_O,
	.PAYLOAD_STATE_O
);

// ===== tb/rssi_event_source.sv
// Framer, wake-up generator and RSSI sampler as seen by the peak unit.
// Assumes the bench calls its tasks; all pulses last one clock.
`timescale 1ns/100ps

module rssi_event_source (
	// Clock
	input  wire logic       clk_i,
	// Samples and events: sync, eom, bit, ch start, ch end, wake-up
	output logic [7:0]      sample_o,
	output logic            valid_o,
	output logic [5:0]      event_o
);
	initial begin
		sample_o = 8'h00;
		valid_o  = 1'b0;
		event_o  = 6'h00;
	end

	// Sample line is scrambled once unqualified so stale data cannot pass
	task automatic send(input logic [7:0] v);
		@(posedge clk_i);
		sample_o <= v;
		valid_o  <= 1'b1;
		@(posedge clk_i);
		sample_o <= ~v;
		valid_o  <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic flush(input logic [7:0] v);
		repeat (4) send(v);
	endtask

	task automatic pulse(input int idx);
		@(posedge clk_i);
		event_o[idx] <= 1'b1;
		@(posedge clk_i);
		event_o[idx] <= 1'b0;
	endtask
endmodule

// ===== tb/tb_rssi_peak_detector_unit.sv
// Self-checking bench of the RSSI peak detector unit.
// Assumes the event source model and the bound checker.
`timescale 1ns/100ps
`include "rssi_peak_defines.svh"

module tb_rssi_peak_detector_unit;
	import rssi_peak_pkg::*;

	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        rx_run;
	logic        wu_search;
	logic [7:0]  smp;
	logic        smp_vld;
	logic [5:0]  ev;
	logic        frame_sync_detected;
	logic        end_of_message;
	logic        dbit;
	logic        ch_start;
	logic        ch_end;
	logic        wake;
	logic        trk;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	pay_state_t  st;
	logic [31:0] d;
	logic        e;
	int          error_cnt = 0;
	int          checks_done = 0;

	assign {wake, ch_end, ch_start, dbit, end_of_message, frame_sync_detected} = ev;

	rssi_peak_detector_unit DUT (
		.CLOCK_I               (clk),
		.RST_I                 (rst),
		.PSEL_I                (psel),
		.PENABLE_I             (penable),
		.PWRITE_I              (pwrite),
		.PADDR_I               (paddr),
		.PWDATA_I              (pwdata),
		.PRDATA_O              (prdata),
		.PREADY_O              (pready),
		.PSLVERR_O             (pslverr),
		.RSSI_SAMPLE_I         (smp),
		.RSSI_VALID_I          (smp_vld),
		.FRAME_SYNC_DETECTED_I (frame_sync_detected),
		.END_OF_MESSAGE_I      (end_of_message),
		.DATA_BIT_I            (dbit),
		.RX_RUN_I              (rx_run),
		.WAKEUP_SEARCH_I       (wu_search),
		.CHANNEL_START_I       (ch_start),
		.CHANNEL_END_I         (ch_end),
		.WAKEUP_I              (wake),
		.PAYLOAD_TRACKING_O    (trk),
		.PAYLOAD_STATE_O       (st)
	);

	rssi_event_source pm (
		.clk_i    (clk),
		.sample_o (smp),
		.valid_o  (smp_vld),
		.event_o  (ev)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0, d, e);
		chk(d, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v, d, e);
		chk({31'h0, e}, 32'h0);
	endtask

	task automatic chk_st(input pay_state_t s);
		@(posedge clk);
		chk({29'h0, st}, {29'h0, s});
		chk({31'h0, trk}, {31'h0, s == PAY_TRACK});
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rd_chk(`PAYLOAD_PEAK_OFS, 32'h0, 1'b0);
		rd_chk(`RX_PEAK_OFS, 32'h0, 1'b0);
		rd_chk(`WAKEUP_PEAK_OFS, 32'h0, 1'b0);
		rd_chk(`PEAK_CONFIG_OFS, 32'h0, 1'b0);
		rd_chk(`PEAK_STATUS_OFS, 32'h0, 1'b0);
		rd_chk(8'h14, 32'h0, 1'b1);
	endtask

	// High level only during the delay; the average still carries it a while
	task automatic t_payload_delay;
		wr(`PEAK_CONFIG_OFS, 32'h2);
		rd_chk(`PEAK_CONFIG_OFS, 32'h2, 1'b0);
		pm.pulse(0);
		chk_st(PAY_DELAY);
		pm.flush(8'hC8);
		pm.pulse(2);
		chk_st(PAY_DELAY);
		pm.pulse(2);
		chk_st(PAY_TRACK);
		pm.flush(8'h08);
		rd_chk(`PAYLOAD_PEAK_OFS, 32'h0, 1'b0);
		pm.pulse(1);
		rd_chk(`PAYLOAD_PEAK_OFS, 32'h98, 1'b0);
		wr(`PAYLOAD_PEAK_OFS, 32'hFF);
		rd_chk(`PAYLOAD_PEAK_OFS, 32'h98, 1'b0);
	endtask

	task automatic t_payload_again;
		wr(`PEAK_CONFIG_OFS, 32'h0);
		pm.pulse(0);
		chk_st(PAY_TRACK);
		pm.flush(8'h0C);
		pm.pulse(1);
		rd_chk(`PAYLOAD_PEAK_OFS, 32'hC, 1'b0);
		pm.send(8'hC8);
		pm.pulse(1);
		rd_chk(`PAYLOAD_PEAK_OFS, 32'hC, 1'b0);
	endtask

	// Reads come faster than a gain-controlled receiver would allow; none runs here
	task automatic t_rx;
		pm.flush(8'h28);
		rd_chk(`RX_PEAK_OFS, 32'h0, 1'b0);
		@(posedge clk);
		rx_run <= 1'b1;
		pm.send(8'h78);
		pm.send(8'h00);
		pm.send(8'h00);
		rd_chk(`RX_PEAK_OFS, 32'h3C, 1'b0);
		rd_chk(`RX_PEAK_OFS, 32'h28, 1'b0);
		rd_chk(`PEAK_STATUS_OFS, 32'h9, 1'b0);
		wr(`PEAK_STATUS_OFS, 32'h1);
		rd_chk(`PEAK_STATUS_OFS, 32'h8, 1'b0);
		@(posedge clk);
		rx_run <= 1'b0;
		pm.send(8'hC8);
		rd_chk(`RX_PEAK_OFS, 32'h28, 1'b0);
		rd_chk(`RX_PEAK_OFS, 32'h28, 1'b0);
		// Stopped reads must not have restarted the detector from the higher level
		@(posedge clk);
		rx_run <= 1'b1;
		rd_chk(`RX_PEAK_OFS, 32'h28, 1'b0);
		@(posedge clk);
		rx_run <= 1'b0;
	endtask

	// Reset in mid-run, with every peak register holding a nonzero value
	task automatic t_rst_again;
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk_st(PAY_IDLE);
		rd_chk(`PAYLOAD_PEAK_OFS, 32'h0, 1'b0);
		rd_chk(`RX_PEAK_OFS, 32'h0, 1'b0);
		rd_chk(`WAKEUP_PEAK_OFS, 32'h0, 1'b0);
	endtask

	task automatic t_wakeup;
		pm.flush(8'h14);
		@(posedge clk);
		wu_search <= 1'b1;
		pm.pulse(3);
		pm.send(8'h14);
		pm.pulse(4);
		rd_chk(`WAKEUP_PEAK_OFS, 32'h14, 1'b0);
		pm.pulse(3);
		pm.send(8'h04);
		pm.pulse(4);
		rd_chk(`WAKEUP_PEAK_OFS, 32'h10, 1'b0);
		pm.pulse(3);
		pm.send(8'h64);
		pm.pulse(5);
		rd_chk(`WAKEUP_PEAK_OFS, 32'h24, 1'b0);
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		rst       = 1'b1;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		rx_run    = 1'b0;
		wu_search = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_payload_delay;
		t_payload_again;
		t_rx;
		t_wakeup;
		t_rst_again;
		conclude;
	end

	initial begin
		#20000;
		error_cnt++;
		conclude;
	end
endmodule
